/* hw/uscs_pkg.sv */
package uscs_pkg;

    // =========================================================
    // register map, byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_BAUD = 8'h10;

    // =========================================================
    // serial_port_control fields
    localparam int BIT_MODE = 7;
    localparam int BIT_ONE = 6;
    localparam int BIT_MCE = 5;
    localparam int BIT_REN = 4;
    localparam int BIT_TB8 = 3;
    localparam int BIT_RB8 = 2;
    localparam int BIT_TI = 1;
    localparam int BIT_RI = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;

    // =========================================================
    // interrupt status and mask fields
    localparam int ST_RX = 0;
    localparam int ST_TX = 1;
    localparam int ST_OVR = 2;
    localparam int ST_W = 3;
    localparam logic [2:0] STAT_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // =========================================================
    // bit timing: cycles per bit, 868 gives 115200 baud at 100 MHz
    localparam int BAUD_W = 16;
    localparam logic [15:0] BAUD_RESET = 16'h0364;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    // =========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        USCS_IDLE,
        USCS_START,
        USCS_DATA,
        USCS_NINTH,
        USCS_STOP
    } uscs_bit_state_t;

endpackage : uscs_pkg

/* hw/uscs_serial_ctrl.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module uscs_serial_ctrl
    import uscs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic uart_rxd,
    output logic uart_txd,
    output logic irq
);

    // =========================================================
    // reset release
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // =========================================================
    // register state
    logic mode_q;
    logic mce_q;
    logic ren_q;
    logic tb8_q;
    logic rb8_q;
    logic ti_q;
    logic ri_q;
    logic [7:0] rxbuf_q;
    logic [ST_W-1:0] stat_q;
    logic [ST_W-1:0] mask_q;
    logic [BAUD_W-1:0] baud_q;
    logic [7:0] ctrl_rd;

    // =========================================================
    // axi4-lite write channel
    logic aw_got_q;
    logic w_got_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_hit;
    logic wr_lo;

    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_lo = wr_fire && w_strb_q[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_got_q <= 1'b0;
        end else if (!aw_got_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_got_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_got_q <= 1'b0;
        end else if (!w_got_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_comb begin
        wr_hit = (aw_addr_q[7:0] == OFF_CTRL) || (aw_addr_q[7:0] == OFF_DATA) ||
            (aw_addr_q[7:0] == OFF_STAT) || (aw_addr_q[7:0] == OFF_MASK) ||
            (aw_addr_q[7:0] == OFF_BAUD);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_data;
    assign wr_ctrl = wr_lo && aw_addr_q[7:0] == OFF_CTRL;
    assign wr_data = wr_lo && aw_addr_q[7:0] == OFF_DATA;

    // =========================================================
    // axi4-lite read channel
    logic [31:0] rd_mux;

    always_comb begin
        ctrl_rd = {mode_q, 1'b1, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
        rd_mux = '0;
        unique case (s_axi_araddr[7:0])
            OFF_CTRL: rd_mux = {24'h000000, ctrl_rd};
            OFF_DATA: rd_mux = {24'h000000, rxbuf_q};
            OFF_STAT: rd_mux = {29'h00000000, stat_q};
            OFF_MASK: rd_mux = {29'h00000000, mask_q};
            OFF_BAUD: rd_mux = {16'h0000, baud_q};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (s_axi_araddr[7:0] == OFF_CTRL || s_axi_araddr[7:0] == OFF_DATA ||
                s_axi_araddr[7:0] == OFF_STAT || s_axi_araddr[7:0] == OFF_MASK ||
                s_axi_araddr[7:0] == OFF_BAUD) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // =========================================================
    // bit timers, restarted at each frame start
    uscs_tick_if tx_tif ();
    uscs_tick_if rx_tif ();

    uscs_tick u_tx_tick (
        .clk(sys_clk),
        .rst_n(rst_n),
        .tif(tx_tif.timer)
    );

    uscs_tick u_rx_tick (
        .clk(sys_clk),
        .rst_n(rst_n),
        .tif(rx_tif.timer)
    );

    // =========================================================
    // transmitter
    uscs_bit_state_t tx_state_q;
    logic [7:0] tx_shift_q;
    logic [3:0] tx_cnt_q;
    logic tx_start;
    logic tx_done_set;

    // a write while a frame is on the line is dropped, not queued
    assign tx_start = wr_data && tx_state_q == USCS_IDLE;
    assign tx_tif.period = baud_q;
    assign tx_tif.restart = tx_start;
    assign tx_done_set = tx_tif.tick &&
        ((tx_state_q == USCS_DATA && tx_cnt_q == LAST_DATA_BIT && !mode_q) ||
        tx_state_q == USCS_NINTH);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= USCS_IDLE;
            tx_shift_q <= '0;
            tx_cnt_q <= '0;
            uart_txd <= 1'b1;
        end else if (tx_start) begin
            tx_state_q <= USCS_START;
            tx_shift_q <= w_data_q[7:0];
            tx_cnt_q <= '0;
            uart_txd <= 1'b0;
        end else if (tx_tif.tick) begin
            unique case (tx_state_q)
                USCS_IDLE: begin
                    uart_txd <= 1'b1;
                end
                USCS_START: begin
                    tx_state_q <= USCS_DATA;
                    uart_txd <= tx_shift_q[0];
                end
                USCS_DATA: begin
                    if (tx_cnt_q == LAST_DATA_BIT) begin
                        if (mode_q) begin
                            tx_state_q <= USCS_NINTH;
                            uart_txd <= tb8_q;
                        end else begin
                            tx_state_q <= USCS_STOP;
                            uart_txd <= 1'b1;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        uart_txd <= tx_shift_q[1];
                    end
                end
                USCS_NINTH: begin
                    tx_state_q <= USCS_STOP;
                    uart_txd <= 1'b1;
                end
                USCS_STOP: begin
                    tx_state_q <= USCS_IDLE;
                    uart_txd <= 1'b1;
                end
            endcase
        end
    end

    // =========================================================
    // receiver
    uscs_bit_state_t rx_state_q;
    logic [7:0] rx_shift_q;
    logic [3:0] rx_cnt_q;
    logic rx_bit9_q;
    logic rx_prev_q;
    logic rx_begin;
    logic rx_end;
    logic rx_qual;
    logic rx_accept;
    logic rx_lost;

    assign rx_begin = rx_state_q == USCS_IDLE && ren_q && rx_prev_q && !uart_rxd;
    assign rx_tif.period = baud_q;
    assign rx_tif.restart = rx_begin;
    assign rx_end = rx_tif.mid && rx_state_q == USCS_STOP;
    assign rx_qual = mode_q ? rx_bit9_q : uart_rxd;
    assign rx_accept = rx_end && !ri_q && (!mce_q || rx_qual);
    assign rx_lost = rx_end && ri_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= uart_rxd;
        end
    end

    // stop is left at its midpoint so a following start edge is not missed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= USCS_IDLE;
            rx_shift_q <= '0;
            rx_cnt_q <= '0;
            rx_bit9_q <= 1'b0;
        end else if (rx_begin) begin
            rx_state_q <= USCS_START;
            rx_cnt_q <= '0;
        end else if (rx_tif.mid) begin
            unique case (rx_state_q)
                USCS_IDLE: begin
                    rx_cnt_q <= '0;
                end
                USCS_START: begin
                    rx_state_q <= uart_rxd ? USCS_IDLE : USCS_DATA;
                end
                USCS_DATA: begin
                    rx_shift_q <= {uart_rxd, rx_shift_q[7:1]};
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                    if (rx_cnt_q == LAST_DATA_BIT) begin
                        rx_state_q <= mode_q ? USCS_NINTH : USCS_STOP;
                    end
                end
                USCS_NINTH: begin
                    rx_bit9_q <= uart_rxd;
                    rx_state_q <= USCS_STOP;
                end
                USCS_STOP: begin
                    rx_state_q <= USCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_q <= '0;
        end else if (rx_accept) begin
            rxbuf_q <= rx_shift_q;
        end
    end

    // =========================================================
    // serial_port_control
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= CTRL_RESET[BIT_MODE];
            mce_q <= CTRL_RESET[BIT_MCE];
            ren_q <= CTRL_RESET[BIT_REN];
            tb8_q <= CTRL_RESET[BIT_TB8];
        end else if (wr_ctrl) begin
            mode_q <= w_data_q[BIT_MODE];
            mce_q <= w_data_q[BIT_MCE];
            ren_q <= w_data_q[BIT_REN];
            tb8_q <= w_data_q[BIT_TB8];
        end
    end

    // hardware set beats a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rb8_q <= CTRL_RESET[BIT_RB8];
            ti_q <= CTRL_RESET[BIT_TI];
            ri_q <= CTRL_RESET[BIT_RI];
        end else begin
            if (rx_accept) begin
                rb8_q <= rx_qual;
            end else if (wr_ctrl) begin
                rb8_q <= w_data_q[BIT_RB8];
            end
            if (tx_done_set) begin
                ti_q <= 1'b1;
            end else if (wr_ctrl) begin
                ti_q <= w_data_q[BIT_TI];
            end
            if (rx_accept) begin
                ri_q <= 1'b1;
            end else if (wr_ctrl) begin
                ri_q <= w_data_q[BIT_RI];
            end
        end
    end

    // =========================================================
    // interrupt status, mask, bit period
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= STAT_RESET;
        end else begin
            stat_q <= (wr_lo && aw_addr_q[7:0] == OFF_STAT ?
                stat_q & ~w_data_q[ST_W-1:0] : stat_q) |
                {rx_lost, tx_done_set, rx_accept};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RESET;
        end else if (wr_lo && aw_addr_q[7:0] == OFF_MASK) begin
            mask_q <= w_data_q[ST_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_q <= BAUD_RESET;
        end else if (wr_fire && aw_addr_q[7:0] == OFF_BAUD) begin
            if (w_strb_q[0]) begin
                baud_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                baud_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // registered, so irq trails the status bit by one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

endmodule : uscs_serial_ctrl

/* hw/uscs_tick.sv */
`timescale 1ns/1ps
module uscs_tick
    import uscs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    uscs_tick_if.timer tif
);

    logic [BAUD_W-1:0] cnt_q;
    logic [BAUD_W-1:0] last;
    logic [BAUD_W-1:0] half;

    // =========================================================
    // bit period divider
    // periods under two run as two cycles, so mid and tick fall on different cycles
    always_comb begin
        last = (tif.period < 16'h0002) ? 16'h0001 : tif.period - 16'h0001;
        half = {1'b0, last[BAUD_W-1:1]};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (tif.restart || cnt_q >= last) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tif.tick <= 1'b0;
            tif.mid <= 1'b0;
        end else begin
            tif.tick <= !tif.restart && cnt_q >= last;
            tif.mid <= !tif.restart && cnt_q == half;
        end
    end

endmodule : uscs_tick

/* hw/uscs_tick_if.sv */
`timescale 1ns/1ps
interface uscs_tick_if;
    logic [15:0] period;
    logic restart;
    logic tick;
    logic mid;

    modport owner (output period, output restart, input tick, input mid);
    modport timer (input period, input restart, output tick, output mid);
endinterface : uscs_tick_if

/* testbench/test_uart_serial_control_status.sv */
`timescale 1ns/1ps
// =========================================================
// register level tests against the peer
module test_uart_serial_control_status;
    import uscs_pkg::*;
    logic sys_clk, rst_b, uart_rxd, uart_txd, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [10:0] rx_frame;
    int rx_cnt;
    int fails = 0;
    int num_checks = 0;

    uscs_serial_ctrl #(.ADDR_W(8)) uscs_serial_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .uart_rxd(uart_rxd), .uart_txd(uart_txd), .irq(irq));
    uscs_peer #(.BIT(8)) uscs_peer_i (.sys_clk(sys_clk), .uart_rxd(uart_rxd),
        .uart_txd(uart_txd), .rx_frame(rx_frame), .rx_cnt(rx_cnt));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge sys_clk);
            if (aw && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w = 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        while (s_axi_arready !== 1'b1) @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd

    // flags stay set until cleared, so each frame starts clean
    task automatic tx_frame(input logic [7:0] c, input logic [7:0] d, input logic [10:0] ef);
        int n0;
        wr(OFF_STAT, 32'h7, RESP_OKAY);
        wr(OFF_CTRL, {24'h0, c}, RESP_OKAY);
        n0 = rx_cnt;
        wr(OFF_DATA, {24'h0, d}, RESP_OKAY);
        while (rx_cnt == n0) @(posedge sys_clk);
        chk(32'(rx_frame), 32'(ef));
        repeat (20) @(posedge sys_clk);
        rd(OFF_CTRL, {24'h0, c | 8'h42}, RESP_OKAY);
        chk(32'(irq), 32'h1);
    endtask : tx_frame

    task automatic rx_frame_t(input logic [7:0] c, input logic [7:0] d, input logic b9,
                              input logic stop, input logic [7:0] ec);
        wr(OFF_CTRL, {24'h0, c}, RESP_OKAY);
        @(posedge sys_clk);
        uscs_peer_i.send(d, b9, c[BIT_MODE], stop);
        repeat (4) @(posedge sys_clk);
        rd(OFF_CTRL, {24'h0, ec}, RESP_OKAY);
    endtask : rx_frame_t

    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        rst_b = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        s_axi_wstrb <= 4'hF;
        while (s_axi_awready !== 1'b1) @(posedge sys_clk);
        rd(OFF_CTRL, 32'h40, RESP_OKAY);
        rd(OFF_STAT, 32'h0, RESP_OKAY);
        rd(OFF_MASK, 32'h0, RESP_OKAY);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h0, RESP_SLVERR);
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_CTRL, 32'h40, RESP_OKAY);
        wr(OFF_BAUD, 32'h8, RESP_OKAY);
        wr(OFF_MASK, 32'h7, RESP_OKAY);
        tx_frame(8'h00, 8'hA5, {2'b11, 8'hA5, 1'b0});
        tx_frame(8'h88, 8'h3C, {2'b11, 8'h3C, 1'b0});
        tx_frame(8'h80, 8'hC3, {2'b10, 8'hC3, 1'b0});
        wr(OFF_STAT, 32'h7, RESP_OKAY);
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        rx_frame_t(8'h00, 8'h55, 1'b0, 1'b1, 8'h40);
        rx_frame_t(8'h10, 8'h5A, 1'b0, 1'b1, 8'h55);
        chk(32'(irq), 32'h1);
        @(posedge sys_clk);
        uscs_peer_i.send(8'h11, 1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge sys_clk);
        rd(OFF_DATA, 32'h5A, RESP_OKAY);
        rd(OFF_STAT, 32'h5, RESP_OKAY);
        wr(OFF_MASK, 32'h0, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        wr(OFF_MASK, 32'h7, RESP_OKAY);
        wr(OFF_STAT, 32'h7, RESP_OKAY);
        rx_frame_t(8'h30, 8'h22, 1'b0, 1'b0, 8'h70);
        rx_frame_t(8'h10, 8'h22, 1'b0, 1'b0, 8'h51);
        rd(OFF_DATA, 32'h22, RESP_OKAY);
        rx_frame_t(8'hB0, 8'h33, 1'b0, 1'b1, 8'hF0);
        rx_frame_t(8'hB0, 8'h44, 1'b1, 1'b0, 8'hF5);
        rd(OFF_DATA, 32'h44, RESP_OKAY);
        end_sim();
    end
endmodule : test_uart_serial_control_status

/* testbench/uscs_peer.sv */
`timescale 1ns/1ps
// =========================================================
// remote transceiver: sends on rxd, records frames seen on txd
module uscs_peer #(
    parameter int BIT = 8
) (
    input wire logic sys_clk,
    output logic uart_rxd,
    input wire logic uart_txd,
    output logic [10:0] rx_frame,
    output int rx_cnt
);
    initial begin
        uart_rxd = 1'b1;
        rx_frame = 11'h000;
        rx_cnt = 0;
    end

    // start, data lsb first, optional ninth, stop; line idles high
    task automatic send(input logic [7:0] d, input logic b9, input logic nine_m,
                        input logic stop);
        logic [10:0] f;
        int n;
        f = {stop, b9, d, 1'b0};
        n = nine_m ? 11 : 10;
        if (!nine_m) f[9] = stop;
        for (int i = 0; i < n; i++) begin
            uart_rxd <= f[i];
            repeat (BIT) @(posedge sys_clk);
        end
        uart_rxd <= 1'b1;
    endtask : send

    // samples mid bit; first bit of the device is one cycle longer
    initial begin
        forever begin
            @(negedge uart_txd);
            repeat (BIT / 2 + 1) @(posedge sys_clk);
            for (int i = 0; i < 11; i++) begin
                rx_frame[i] = uart_txd;
                repeat (BIT) @(posedge sys_clk);
            end
            rx_cnt++;
        end
    end
endmodule : uscs_peer

/* testbench/uscs_sva.sv */
`timescale 1ns/1ps
// =========================================================
// port checks on the control block
module uscs_sva
    import uscs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic uart_rxd,
    input wire logic uart_txd,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // assumes the bench programs eight cycles per bit
    sequence bit_low;
        !uart_txd [*8];
    endsequence

    reset_idle_a: assert property ($rose(rst_b) |-> uart_txd && !irq && !s_axi_bvalid)
        else $error("line or irq not idle out of reset");
    write_answer_a: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    bit_width_a: assert property ($fell(uart_txd) |-> bit_low)
        else $error("low bit on line too short");

    // remembers whether the pending read targets the control register
    logic ctrl_rd_q;
    always_ff @(posedge sys_clk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ctrl_rd_q <= s_axi_araddr[7:0] == OFF_CTRL;
        end
    end
    ctrl_bit6_a: assert property (s_axi_rvalid && ctrl_rd_q |-> s_axi_rdata[BIT_ONE])
        else $error("control bit six read as zero");
endmodule : uscs_sva

bind uscs_serial_ctrl uscs_sva #(.ADDR_W(ADDR_W)) uscs_sva_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .uart_rxd(uart_rxd),
    .uart_txd(uart_txd), .irq(irq));
